// *** design/dcs_pkg.sv ***
// Package for the device clock source switch: register map, fields, states.
// Assumes a 10 MHz system clock and a classic Wishbone register bus.
package dcs_pkg;

    // Register word addresses (byte addresses, 32-bit words)
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_TUNE   = 4'h4;
    localparam logic [3:0] ADDR_T1CTRL = 4'h8;

    // Control register fields
    localparam int IDLE_BIT   = 7;
    localparam int FREQ_LSB   = 4;
    localparam int STO_BIT    = 3;
    localparam int IOS_BIT    = 2;
    localparam int SRC_LSB    = 0;
    // Tuning register fields
    localparam int LFP_BIT    = 7;
    // Timer one control fields
    localparam int SRUN_BIT   = 6;
    localparam int SOEN_BIT   = 3;

    localparam logic [2:0] FREQ_RESET = 3'h4;
    localparam logic [1:0] SRC_PRI    = 2'h0;
    localparam logic [1:0] SRC_SEC    = 2'h1;

    // Switch pause: two old cycles plus four new cycles (upper end of three to four)
    localparam logic [2:0] PAUSE_OLD  = 3'h2;
    localparam logic [2:0] PAUSE_NEW  = 3'h4;

    // Stability wait of the fast internal oscillator, in ns
    localparam int FAST_STABLE_NS = 1000;
    localparam int CLK_NS         = 100;
    localparam int FAST_STABLE_CYC = (FAST_STABLE_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0] {
        SW_RUN      = 2'b00,
        SW_OLD_WAIT = 2'b01,
        SW_NEW_WAIT = 2'b10
    } dcs_sw_t;

    typedef struct packed {
        logic        idle_on_sleep;
        logic [2:0]  internal_freq_select;
        logic [1:0]  source_select;
        logic        low_freq_source_pick;
        logic [4:0]  tune;
        logic        secondary_osc_enable;
        logic [1:0]  active_src;
        logic [1:0]  pending_src;
        dcs_sw_t     sw;
        logic [2:0]  pause_cnt;
        logic        clk_gate;
        logic [7:0]  stable_cnt;
        logic        fast_stable;
        logic        wb_ack;
        logic [31:0] wb_dat;
        logic [1:0]  sleep_mode;
        logic [2:0]  fast_div_sel;
        logic        fast_osc_en;
        logic        slow_rc_en;
        logic        pri_ready_s1;
        logic        pri_ready_s2;
        logic        sec_ready_s1;
        logic        sec_ready_s2;
        logic        sleep_s1;
        logic        sleep_s2;
        logic        sleep_s3;
    } dcs_state_t;

endpackage

// *** design/dcs_switch.sv ***
// Device clock source switch with control, tuning and timer one control registers.
// Assumes the oscillators live outside; this block issues selects, gates and modes.
//
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/1ns

module dcs_switch #(
    parameter int STABLE_CYC = dcs_pkg::FAST_STABLE_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        switchover_config_i,
    input  wire logic        primary_ready_i,
    input  wire logic        secondary_ready_i,
    input  wire logic        sleep_req_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic [1:0]       active_src_o,
    output logic             clk_gate_o,
    output logic [2:0]       fast_div_sel_o,
    output logic             fast_osc_en_o,
    output logic             slow_rc_en_o,
    output logic             secondary_osc_en_o,
    output logic [1:0]       sleep_mode_o
);

    initial
    begin
        if (STABLE_CYC < 1 || STABLE_CYC > 255)
        begin
            $error("STABLE_CYC out of range");
        end
    end

    dcs_pkg::dcs_state_t s_q;
    dcs_pkg::dcs_state_t s_d;
    logic                sto_flag;
    logic                ios_flag;
    logic                srun_flag;
    logic                sto_reset;

    // Internal block chosen whenever the upper select bit is set
    function automatic logic is_int(input logic [1:0] src);
        is_int = src[1];
    endfunction

    // Flags are mutually exclusive since they follow the single active source
    assign sto_flag  = (s_q.active_src == dcs_pkg::SRC_PRI) && s_q.pri_ready_s2 && (s_q.sw == dcs_pkg::SW_RUN);
    assign ios_flag  = is_int(s_q.active_src) && s_q.fast_stable && s_q.fast_osc_en && (s_q.sw == dcs_pkg::SW_RUN);
    assign srun_flag = (s_q.active_src == dcs_pkg::SRC_SEC) && (s_q.sw == dcs_pkg::SW_RUN);

    // Start-up flag reads set right after release when switchover is disabled
    logic sto_cfg_q;
    logic rel_seen_q;
    assign sto_reset = sto_cfg_q ? 1'b0 : 1'b1;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sto_cfg_q  <= 1'b0;
            rel_seen_q <= 1'b0;
        end
        else if (!rel_seen_q)
        begin
            sto_cfg_q  <= switchover_config_i;
            rel_seen_q <= 1'b1;
        end
    end

    always_comb
    begin
        logic        wr;
        logic        rd;
        logic [7:0]  wbyte;
        logic [1:0]  new_src;
        s_d   = s_q;
        wr    = wb_cyc_i && wb_stb_i && wb_we_i && !s_q.wb_ack;
        rd    = wb_cyc_i && wb_stb_i && !s_q.wb_ack;
        wbyte = wb_dat_i[7:0];
        new_src = s_q.source_select;

        s_d.pri_ready_s1 = primary_ready_i;
        s_d.pri_ready_s2 = s_q.pri_ready_s1;
        s_d.sec_ready_s1 = secondary_ready_i;
        s_d.sec_ready_s2 = s_q.sec_ready_s1;
        s_d.sleep_s1     = sleep_req_i;
        s_d.sleep_s2     = s_q.sleep_s1;
        s_d.sleep_s3     = s_q.sleep_s2;

        s_d.wb_ack = rd;
        s_d.wb_dat = 32'h0000_0000;
        if (rd && !wb_we_i)
        begin
            case (wb_adr_i)
                dcs_pkg::ADDR_CTRL:
                begin
                    s_d.wb_dat[dcs_pkg::IDLE_BIT] = s_q.idle_on_sleep;
                    s_d.wb_dat[dcs_pkg::FREQ_LSB +: 3] = s_q.internal_freq_select;
                    // Without switchover the start-up timer ran out before release
                    s_d.wb_dat[dcs_pkg::STO_BIT] = rel_seen_q ? (sto_flag || (sto_reset
                        && (s_q.active_src == dcs_pkg::SRC_PRI) && (s_q.sw == dcs_pkg::SW_RUN))) : 1'b0;
                    s_d.wb_dat[dcs_pkg::IOS_BIT] = ios_flag;
                    s_d.wb_dat[dcs_pkg::SRC_LSB +: 2] = s_q.source_select;
                end
                dcs_pkg::ADDR_TUNE:
                begin
                    s_d.wb_dat[dcs_pkg::LFP_BIT] = s_q.low_freq_source_pick;
                    s_d.wb_dat[4:0] = s_q.tune;
                end
                dcs_pkg::ADDR_T1CTRL:
                begin
                    s_d.wb_dat[dcs_pkg::SRUN_BIT] = srun_flag;
                    s_d.wb_dat[dcs_pkg::SOEN_BIT] = s_q.secondary_osc_enable;
                end
                default:
                begin
                    s_d.wb_dat = 32'h0000_0000;
                end
            endcase
        end

        if (wr && wb_sel_i[0])
        begin
            case (wb_adr_i)
                dcs_pkg::ADDR_CTRL:
                begin
                    s_d.idle_on_sleep        = wbyte[dcs_pkg::IDLE_BIT];
                    s_d.internal_freq_select = wbyte[dcs_pkg::FREQ_LSB +: 3];
                    new_src = wbyte[dcs_pkg::SRC_LSB +: 2];
                    if (new_src == dcs_pkg::SRC_SEC && !s_q.secondary_osc_enable)
                    begin
                        new_src = s_q.source_select;
                    end
                    s_d.source_select = new_src;
                end
                dcs_pkg::ADDR_TUNE:
                begin
                    s_d.low_freq_source_pick = wbyte[dcs_pkg::LFP_BIT];
                    s_d.tune = wbyte[4:0];
                end
                dcs_pkg::ADDR_T1CTRL:
                begin
                    s_d.secondary_osc_enable = wbyte[dcs_pkg::SOEN_BIT];
                end
                default:
                begin
                    s_d.tune = s_q.tune;
                end
            endcase
        end

        // Glitch-free switch: gate low, count old then new cycles
        case (s_q.sw)
            dcs_pkg::SW_RUN:
            begin
                s_d.clk_gate = 1'b1;
                if (s_d.source_select != s_q.active_src)
                begin
                    s_d.pending_src = s_d.source_select;
                    s_d.sw          = dcs_pkg::SW_OLD_WAIT;
                    s_d.pause_cnt   = dcs_pkg::PAUSE_OLD;
                    s_d.clk_gate    = 1'b0;
                end
            end
            dcs_pkg::SW_OLD_WAIT:
            begin
                s_d.clk_gate  = 1'b0;
                s_d.pause_cnt = s_q.pause_cnt - 3'h1;
                if (s_q.pause_cnt == 3'h1)
                begin
                    s_d.active_src = s_q.pending_src;
                    s_d.sw         = dcs_pkg::SW_NEW_WAIT;
                    s_d.pause_cnt  = dcs_pkg::PAUSE_NEW;
                end
            end
            dcs_pkg::SW_NEW_WAIT:
            begin
                s_d.clk_gate  = 1'b0;
                s_d.pause_cnt = s_q.pause_cnt - 3'h1;
                if (s_q.pause_cnt == 3'h1)
                begin
                    s_d.sw       = dcs_pkg::SW_RUN;
                    s_d.clk_gate = 1'b1;
                end
            end
            default:
            begin
                s_d.sw       = dcs_pkg::SW_RUN;
                s_d.clk_gate = 1'b1;
            end
        endcase

        // Oscillator steering follows the frequency code immediately
        s_d.fast_div_sel = s_d.internal_freq_select;
        s_d.fast_osc_en  = (s_d.internal_freq_select != 3'h0) || s_d.low_freq_source_pick;
        s_d.slow_rc_en   = 1'b1;

        // Fast oscillator needs a settle time after each enable
        if (!s_q.fast_osc_en)
        begin
            s_d.stable_cnt  = 8'h00;
            s_d.fast_stable = 1'b0;
        end
        else if (s_q.stable_cnt < 8'(STABLE_CYC))
        begin
            s_d.stable_cnt = s_q.stable_cnt + 8'h01;
        end
        else
        begin
            s_d.fast_stable = 1'b1;
        end

        // Sleep request is a pin level, edge-detected after synchronising
        if (s_q.sleep_s2 && !s_q.sleep_s3)
        begin
            s_d.sleep_mode = s_q.idle_on_sleep ? 2'h1 : 2'h2;
        end
        else if (!s_q.sleep_s2)
        begin
            s_d.sleep_mode = 2'h0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_q                      <= '0;
            s_q.internal_freq_select <= dcs_pkg::FREQ_RESET;
            s_q.source_select        <= dcs_pkg::SRC_PRI;
            s_q.active_src           <= dcs_pkg::SRC_PRI;
            s_q.pending_src          <= dcs_pkg::SRC_PRI;
            s_q.sw                   <= dcs_pkg::SW_RUN;
            s_q.clk_gate             <= 1'b1;
            s_q.fast_div_sel         <= dcs_pkg::FREQ_RESET;
            s_q.fast_osc_en          <= 1'b1;
            s_q.slow_rc_en           <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign wb_dat_o           = s_q.wb_dat;
    assign wb_ack_o           = s_q.wb_ack;
    assign active_src_o       = s_q.active_src;
    assign clk_gate_o         = s_q.clk_gate;
    assign fast_div_sel_o     = s_q.fast_div_sel;
    assign fast_osc_en_o      = s_q.fast_osc_en;
    assign slow_rc_en_o       = s_q.slow_rc_en;
    assign secondary_osc_en_o = s_q.secondary_osc_enable;
    assign sleep_mode_o       = s_q.sleep_mode;

endmodule

// *** tb/dcs_switch_chk.sv ***
// Checker for the clock source switch, watching the top module's ports only.
// Assumes one clock domain with an active-low asynchronous reset.
`timescale 1ns/1ns
module dcs_switch_chk (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [1:0] active_src_o,
    input  wire logic       clk_gate_o,
    input  wire logic [2:0] fast_div_sel_o,
    input  wire logic       fast_osc_en_o,
    input  wire logic       slow_rc_en_o,
    input  wire logic       secondary_osc_en_o,
    input  wire logic [1:0] sleep_mode_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Two old plus four new cycles, clock held throughout
    sequence s_pause;
        !clk_gate_o [*6] ##1 clk_gate_o;
    endsequence
    property p_gate_len;
        $fell(clk_gate_o) |-> s_pause;
    endproperty
    property p_src_in_pause;
        $changed(active_src_o) |-> !clk_gate_o;
    endproperty
    property p_src_after_old;
        $changed(active_src_o) |-> $past(clk_gate_o, 3) && !$past(clk_gate_o, 2);
    endproperty
    property p_slow_rc;
        slow_rc_en_o;
    endproperty
    property p_reset_vals;
        $rose(rst_n_i) |-> active_src_o == dcs_pkg::SRC_PRI && fast_div_sel_o == dcs_pkg::FREQ_RESET;
    endproperty
    // Enable may trail the code by up to two cycles
    property p_fast_en;
        (fast_div_sel_o != 3'h0) |-> ##[0:2] fast_osc_en_o;
    endproperty
    property p_sec_en;
        (active_src_o == dcs_pkg::SRC_SEC) |-> secondary_osc_en_o;
    endproperty
    property p_sleep_code;
        sleep_mode_o != 2'h3;
    endproperty
    a_gate_len: assert property (p_gate_len) else $error("pause length wrong");
    a_src_in_pause: assert property (p_src_in_pause) else $error("source moved with clock running");
    a_src_after_old: assert property (p_src_after_old) else $error("old source cycles wrong");
    a_slow_rc: assert property (p_slow_rc) else $error("slow RC stopped");
    a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
    a_fast_en: assert property (p_fast_en) else $error("fast osc off for nonzero code");
    a_sec_en: assert property (p_sec_en) else $error("secondary active while disabled");
    a_sleep_code: assert property (p_sleep_code) else $error("bad sleep mode");
endmodule
bind dcs_switch dcs_switch_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .active_src_o(active_src_o),
    .clk_gate_o(clk_gate_o), .fast_div_sel_o(fast_div_sel_o), .fast_osc_en_o(fast_osc_en_o),
    .slow_rc_en_o(slow_rc_en_o), .secondary_osc_en_o(secondary_osc_en_o), .sleep_mode_o(sleep_mode_o));

// *** tb/dcs_switch_tb.sv ***
// Self-checking bench for the clock source switch, Wishbone driven.
// Assumes the checker is bound separately; 10 MHz clock.
`timescale 1ns/1ns
module dcs_switch_tb;
    logic        clk_i, rst_n_i, cfg, slp, cyc, stb, we;
    logic [3:0]  adr, sel;
    logic [31:0] dat, rd_o, rd, lf;
    logic        ack, gate, fen, sen, fsec;
    logic [1:0]  src, smode, s;
    logic [2:0]  fdiv, f;
    logic        lfp, prdy;
    int          num_errors, checked, gate_lo;
    dcs_switch #(.STABLE_CYC(2)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .switchover_config_i(cfg),
        .primary_ready_i(prdy), .secondary_ready_i(1'b1), .sleep_req_i(slp), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd_o),
        .wb_ack_o(ack), .active_src_o(src), .clk_gate_o(gate), .fast_div_sel_o(fdiv), .fast_osc_en_o(fen),
        .slow_rc_en_o(sen), .secondary_osc_en_o(fsec), .sleep_mode_o(smode));
    function logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function logic [31:0] ctrl_v(input logic i, input logic [2:0] fr, input logic t, input logic o,
                                 input logic [1:0] sr);
        return {24'h0, i, fr, t, o, sr};
    endfunction
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One classic cycle; ack waited for under a bound
    task wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 20)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n == 20)
            num_errors++;
        rd = rd_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task end_of_test;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
        if (gate === 1'b0)
            gate_lo <= gate_lo + 1;
    initial
    begin
        repeat (5000) @(posedge clk_i);
        num_errors++;
        end_of_test;
    end
    initial
    begin
        {rst_n_i, slp, cyc, stb, we, adr, dat} = '0;
        sel = 4'hF;
        prdy = 1'b0;
        lf = 32'h716D;
        cfg = lf[0];
        num_errors = 0;
        checked = 0;
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        wb(1'b0, dcs_pkg::ADDR_CTRL, 8'h00);
        chk(rd, ctrl_v(1'b0, 3'h4, 1'b0, 1'b0, 2'h0));
        prdy <= 1'b1;
        repeat (3) @(posedge clk_i);
        wb(1'b0, dcs_pkg::ADDR_CTRL, 8'h00);
        chk(rd, ctrl_v(1'b0, 3'h4, 1'b1, 1'b0, 2'h0));
        wb(1'b0, 4'hC, 8'h00);
        chk(rd, 32'h0);
        wb(1'b1, dcs_pkg::ADDR_CTRL, 8'h41);
        repeat (10) @(posedge clk_i);
        chk(src, 2'h0);
        wb(1'b1, dcs_pkg::ADDR_T1CTRL, 8'h08);
        gate_lo = 0;
        wb(1'b1, dcs_pkg::ADDR_CTRL, 8'h41);
        repeat (10) @(posedge clk_i);
        chk(gate_lo, 6);
        chk(src, 2'h1);
        wb(1'b0, dcs_pkg::ADDR_CTRL, 8'h00);
        chk(rd, ctrl_v(1'b0, 3'h4, 1'b0, 1'b0, 2'h1));
        wb(1'b0, dcs_pkg::ADDR_T1CTRL, 8'h00);
        chk(rd, 32'h48);
        // Code 000 visited with both low-frequency sources
        for (int i = 0; i < 9; i++)
        begin
            lf = lfsr(lf);
            f = i[2:0];
            lfp = (i == 0);
            s = {1'b1, lf[5]};
            wb(1'b1, dcs_pkg::ADDR_TUNE, {lfp, 2'b00, lf[4:0]});
            wb(1'b0, dcs_pkg::ADDR_TUNE, 8'h00);
            chk(rd, {24'h0, lfp, 2'b00, lf[4:0]});
            wb(1'b1, dcs_pkg::ADDR_CTRL, {1'b0, f, 2'b00, s});
            repeat (12) @(posedge clk_i);
            chk(fdiv, f);
            chk(fen, f != 3'h0 || lfp);
            chk({src[1], sen}, 2'b11);
            wb(1'b0, dcs_pkg::ADDR_CTRL, 8'h00);
            chk(rd, ctrl_v(1'b0, f, 1'b0, f != 3'h0 || lfp, s));
        end
        wb(1'b1, dcs_pkg::ADDR_CTRL, 8'hC0);
        slp <= 1'b1;
        repeat (12) @(posedge clk_i);
        chk(smode, 2'h1);
        rst_n_i <= 1'b0;
        slp <= 1'b0;
        cfg <= 1'b0;
        prdy <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk({src, fdiv}, {2'h0, 3'h4});
        rst_n_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        wb(1'b0, dcs_pkg::ADDR_CTRL, 8'h00);
        chk(rd, ctrl_v(1'b0, 3'h4, 1'b1, 1'b0, 2'h0));
        wb(1'b1, dcs_pkg::ADDR_CTRL, 8'h40);
        slp <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk(smode, 2'h2);
        end_of_test;
    end
endmodule
